/* rtl/lcw_regs.svh */
// Constants for the loop current word packer: times, thresholds and bit positions.
`ifndef LCW_REGS_SVH
`define LCW_REGS_SVH

// ****************************************************************
// Timing, times in microseconds as printed, clock in MHz.
// ****************************************************************
`define LCW_CLK_MHZ 25
`define LCW_XFER_US 6500
`define LCW_HART_UPD_US 50000
`define LCW_CONV_ALL_US 80000
`define LCW_HART_DIV 2'h3
// Damping step in 0.01 % per (1 %/s) over one conversion round.
`define LCW_DAMP_STEP (`LCW_CONV_ALL_US / 10000)

// ****************************************************************
// Percent limits in 0.01 %, current thresholds in microamps and status span limits in points.
// ****************************************************************
`define LCW_PCT_MIN 16'shf63c
`define LCW_PCT_MAX 16'sh30d4
`define LCW_LZ_UA 16'h0e10
`define LCW_ZERO_UA 17'sh00fa0
`define LCW_STAT_LO 16'h2710
`define LCW_STAT_HI 16'hc350

// ****************************************************************
// Channel word layout.
// ****************************************************************
`define LCW_BIT_LZ 0
`define LCW_BIT_LF 1
`define LCW_VAL_LSB 4

`endif

/* rtl/lcw_pkg.sv */
// Types shared by the loop current word packer.
`default_nettype none
package lcw_pkg;
	typedef enum logic [1:0] {LCW_LIVE, LCW_SUBST, LCW_LAST} lcw_strat_t;
	typedef enum logic {LCW_IDLE, LCW_PUSH} lcw_xfer_t;
	typedef logic signed [15:0] lcw_pct_t;
endpackage
`default_nettype wire

/* rtl/lcw_fifo.sv */
// Word FIFO between the channel packer and the backplane.
`timescale 1ns/1ps
`default_nettype none
module lcw_fifo #(
	parameter int W = 19,
	parameter int DEPTH = 32
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rstn,
	// Filling side.
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// Draining side.
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0] cnt_r;
	logic push;
	logic pop;

	assign in_ready = cnt_r != (AW+1)'(DEPTH);
	assign push = in_valid && in_ready;
	// The output stage is a register, so a word is popped only into an empty or draining slot.
	assign pop = (cnt_r != '0) && (!out_valid || out_ready);

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wp_r] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wp_r <= AW'(wp_r + 1'b1);
			end
			if (pop) begin
				rp_r <= AW'(rp_r + 1'b1);
			end
			cnt_r <= (AW+1)'(cnt_r + (AW+1)'(push) - (AW+1)'(pop));
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			out_valid <= 1'b0;
			out_data <= '0;
		end else if (pop) begin
			out_valid <= 1'b1;
			out_data <= mem[rp_r];
		end else if (out_ready) begin
			out_valid <= 1'b0;
		end
	end

	fifo_bound_a: assert property (@(posedge clk) disable iff (!rstn)
		cnt_r <= (AW+1)'(DEPTH)) else $error("FIFO count above depth.");
	fifo_full_a: assert property (@(posedge clk) disable iff (!rstn)
		!in_ready && !pop |=> !in_ready) else $error("FIFO full dropped without a pop.");
endmodule // lcw_fifo
`default_nettype wire

/* rtl/lcw_damper.sv */
// Rate limiter that moves a channel value toward its newest measurement.
`timescale 1ns/1ps
`default_nettype none
`include "lcw_regs.svh"
module lcw_damper (
	// Clock and reset.
	input wire logic clk,
	input wire logic rstn,
	// New measurement.
	input wire logic upd,
	input wire lcw_pkg::lcw_pct_t target,
	input wire logic [7:0] rate,
	// Damped value.
	output lcw_pkg::lcw_pct_t val
);
	import lcw_pkg::*;
	logic signed [16:0] diff;
	logic signed [16:0] step;
	logic signed [16:0] moved;
	lcw_pct_t prev_r;

	assign diff = 17'(target) - 17'(val);
	assign step = 17'(rate) * 17'(`LCW_DAMP_STEP);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			val <= '0;
		end else if (upd) begin
			if (rate == 8'h00 || (diff <= step && diff >= -step)) begin
				val <= target;
			end else if (diff > 0) begin
				val <= 16'(17'(val) + step);
			end else begin
				val <= 16'(17'(val) - step);
			end
		end
	end

	// Helper for the checks only.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			prev_r <= '0;
		end else begin
			prev_r <= val;
		end
	end
	assign moved = 17'(val) - 17'(prev_r);

	damp_off_a: assert property (@(posedge clk) disable iff (!rstn)
		upd && rate == 8'h00 |=> val == $past(target)) else $error("Disabled damping altered value.");
	damp_step_a: assert property (@(posedge clk) disable iff (!rstn)
		upd && rate != 8'h00 |=> moved <= $past(step) && moved >= -$past(step)) else $error("Damping step too large.");
endmodule // lcw_damper
`default_nettype wire

/* rtl/lcw_packer.sv */
// Four channel loop current readout that packs channel words for the backplane.
`timescale 1ns/1ps
`default_nettype none
`include "lcw_regs.svh"
module lcw_packer #(
	parameter int NCH = 4,
	parameter int DEPTH = 32,
	parameter int XFER_CYC = `LCW_XFER_US * `LCW_CLK_MHZ,
	parameter int HART_CYC = `LCW_HART_UPD_US * `LCW_CLK_MHZ,
	parameter int CONV_CYC = `LCW_CONV_ALL_US * `LCW_CLK_MHZ / NCH
) (
	// Clock and reset.
	input wire logic CLK,
	input wire logic RSTN,
	// Converter front end.
	output logic CONV_REQ,
	output logic [1:0] CONV_CH,
	input wire logic ADC_DONE,
	input wire logic [1:0] ADC_CH,
	input wire logic [15:0] ADC_UA,
	// Module configuration.
	input wire logic [15:0] START_PTS,
	input wire logic [15:0] END_PTS,
	input wire logic HART_ACTIVE,
	input wire logic SCAN_EN,
	// Channel configuration.
	input wire logic SIM_MODE [NCH],
	input wire lcw_pkg::lcw_pct_t SIM_PCT [NCH],
	input wire logic SIM_INV [NCH],
	input wire lcw_pkg::lcw_strat_t ERR_MODE [NCH],
	input wire lcw_pkg::lcw_pct_t SUB_PCT [NCH],
	input wire logic LF_EN [NCH],
	input wire logic [15:0] BRK_UA [NCH],
	input wire logic [15:0] SC_UA [NCH],
	input wire logic [7:0] RATE [NCH],
	input wire logic HART_ON [NCH],
	// HART background scan.
	output logic HART_SCAN_REQ,
	output logic [1:0] HART_SCAN_CH,
	// Backplane word stream.
	output logic OUT_VALID,
	input wire logic OUT_READY,
	output logic [15:0] OUT_WORD,
	output logic [1:0] OUT_CH,
	output logic OUT_INVALID
);
	import lcw_pkg::*;

	// ****************************************************************
	// Helpers.
	// ****************************************************************
	function automatic lcw_pct_t lcw_clamp(input logic signed [19:0] v);
		lcw_pct_t r;
		if (v < `LCW_PCT_MIN) begin
			r = `LCW_PCT_MIN;
		end else if (v > `LCW_PCT_MAX) begin
			r = `LCW_PCT_MAX;
		end else begin
			r = 16'(v);
		end
		return r;
	endfunction

	// Percent in 0.01 % to points; the division by 10000 is a reciprocal multiply to avoid a divider.
	// The 44-bit reciprocal is exact for every product below 2^30, and the sign is taken off first
	// so that negative products round toward zero just like positive ones.
	function automatic logic [15:0] lcw_scale(input lcw_pct_t pct, input logic [15:0] lo, input logic [15:0] hi);
		logic signed [17:0] span;
		logic signed [47:0] p;
		logic [63:0] mag;
		logic signed [47:0] q;
		logic signed [47:0] s;
		logic [15:0] r;
		span = 18'($signed({2'b00, hi})) - 18'($signed({2'b00, lo}));
		p = 48'(pct) * 48'(span);
		mag = (p < 0) ? 64'(-p) : 64'(p);
		mag = (mag * 64'h0000_0000_68db_8bad) >> 44;
		q = $signed(48'(mag));
		s = (p < 0) ? -q : q;
		s = s + 48'($signed({32'h0000_0000, lo}));
		if (s < 0) begin
			r = 16'h0000;
		end else if (s > 48'sh00000000ffff) begin
			r = 16'hffff;
		end else begin
			r = 16'(s);
		end
		return r;
	endfunction

	// ****************************************************************
	// Per-channel measurement, selection and word packing.
	// ****************************************************************
	logic lz_r [NCH];
	logic lf_r [NCH];
	logic upd_r [NCH];
	lcw_pct_t meas_r [NCH];
	lcw_pct_t last_r [NCH];
	lcw_pct_t dv [NCH];
	lcw_pct_t sel_pct [NCH];
	logic inv_w [NCH];
	logic [15:0] pts [NCH];
	logic [15:0] word_w [NCH];
	logic status_ok;

	assign status_ok = START_PTS >= `LCW_STAT_LO && END_PTS <= `LCW_STAT_HI;

	for (genvar i = 0; i < NCH; i++) begin : g_ch
		logic signed [16:0] d;
		logic signed [19:0] m;
		assign d = 17'($signed({1'b0, ADC_UA})) - `LCW_ZERO_UA;
		// 4..20 mA maps to 0..10000, so one microamp is 5/8 of 0.01 %.
		assign m = (20'(d) * 20'sd5) >>> 3;

		always_ff @(posedge CLK or negedge RSTN) begin
			if (!RSTN) begin
				lz_r[i] <= 1'b0;
				lf_r[i] <= 1'b0;
				meas_r[i] <= '0;
			end else if (ADC_DONE && ADC_CH == 2'(i)) begin
				lz_r[i] <= ADC_UA <= `LCW_LZ_UA;
				lf_r[i] <= LF_EN[i] && (ADC_UA < BRK_UA[i] || ADC_UA > SC_UA[i]);
				meas_r[i] <= lcw_clamp(m);
			end
		end

		always_ff @(posedge CLK or negedge RSTN) begin
			if (!RSTN) begin
				upd_r[i] <= 1'b0;
			end else begin
				upd_r[i] <= ADC_DONE && ADC_CH == 2'(i);
			end
		end

		lcw_damper u_damp (
			.clk(CLK),
			.rstn(RSTN),
			.upd(upd_r[i]),
			.target(meas_r[i]),
			.rate(RATE[i]),
			.val(dv[i])
		);

		// Last valid value is frozen as soon as a fault is seen.
		always_ff @(posedge CLK or negedge RSTN) begin
			if (!RSTN) begin
				last_r[i] <= '0;
			end else if (!lf_r[i]) begin
				last_r[i] <= dv[i];
			end
		end

		always_comb begin
			sel_pct[i] = dv[i];
			inv_w[i] = 1'b0;
			if (SIM_MODE[i]) begin
				sel_pct[i] = lcw_clamp(20'(SIM_PCT[i]));
				inv_w[i] = SIM_INV[i];
			end else if (lf_r[i]) begin
				case (ERR_MODE[i])
					LCW_SUBST: begin
						sel_pct[i] = lcw_clamp(20'(SUB_PCT[i]));
						inv_w[i] = 1'b1;
					end
					LCW_LAST: begin
						sel_pct[i] = last_r[i];
					end
					default: begin
						sel_pct[i] = dv[i];
					end
				endcase
			end
		end

		assign pts[i] = lcw_scale(sel_pct[i], START_PTS, END_PTS);
		// Same layout for every channel.
		assign word_w[i] = status_ok ?
			{pts[i][15:`LCW_VAL_LSB], 2'b00, lf_r[i], lz_r[i]} : pts[i];
	end

	// ****************************************************************
	// Conversion sequencer and HART background scan.
	// ****************************************************************
	logic [20:0] conv_cnt_r;
	logic [1:0] conv_ch_r;
	logic conv_tick;

	assign conv_tick = conv_cnt_r == 21'(CONV_CYC - 1);

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			conv_cnt_r <= '0;
			conv_ch_r <= 2'h0;
		end else if (conv_tick) begin
			conv_cnt_r <= '0;
			conv_ch_r <= 2'(conv_ch_r + 2'h1);
		end else begin
			conv_cnt_r <= 21'(conv_cnt_r + 21'h1);
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			CONV_REQ <= 1'b0;
			CONV_CH <= 2'h0;
			HART_SCAN_REQ <= 1'b0;
			HART_SCAN_CH <= 2'h0;
		end else begin
			CONV_REQ <= conv_tick;
			CONV_CH <= conv_ch_r;
			// The scan rides on the conversion slot so each active HART channel is visited in turn.
			HART_SCAN_REQ <= conv_tick && SCAN_EN && HART_ACTIVE && HART_ON[conv_ch_r];
			HART_SCAN_CH <= conv_ch_r;
		end
	end

	// ****************************************************************
	// Backplane transfer.
	// ****************************************************************
	logic [20:0] xfer_cnt_r;
	logic [1:0] cyc3_r;
	logic [20:0] hart_wait_r;
	logic tick;
	logic go;
	lcw_xfer_t st_r;
	logic [1:0] idx_r;
	logic [15:0] snap_w [NCH];
	logic snap_i [NCH];
	logic fifo_in_ready;
	logic [18:0] fifo_out;

	assign tick = xfer_cnt_r == 21'(XFER_CYC - 1);
	// A tick that lands while the set is still being pushed into the FIFO is skipped rather than mixed into a half-sent set.
	assign go = tick && st_r == LCW_IDLE &&
		(!HART_ACTIVE || (cyc3_r == 2'h0 && hart_wait_r == '0));

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			xfer_cnt_r <= '0;
			cyc3_r <= 2'h0;
		end else if (tick) begin
			xfer_cnt_r <= '0;
			cyc3_r <= (cyc3_r == `LCW_HART_DIV - 2'h1) ? 2'h0 : 2'(cyc3_r + 2'h1);
		end else begin
			xfer_cnt_r <= 21'(xfer_cnt_r + 21'h1);
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			hart_wait_r <= '0;
		end else if (go && HART_ACTIVE) begin
			hart_wait_r <= 21'(HART_CYC - 1);
		end else if (hart_wait_r != '0) begin
			hart_wait_r <= 21'(hart_wait_r - 21'h1);
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			for (int k = 0; k < NCH; k++) begin
				snap_w[k] <= 16'h0000;
				snap_i[k] <= 1'b0;
			end
		end else if (go) begin
			for (int k = 0; k < NCH; k++) begin
				snap_w[k] <= word_w[k];
				snap_i[k] <= inv_w[k];
			end
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			st_r <= LCW_IDLE;
			idx_r <= 2'h0;
		end else begin
			case (st_r)
				LCW_IDLE: begin
					if (go) begin
						st_r <= LCW_PUSH;
						idx_r <= 2'h0;
					end
				end
				LCW_PUSH: begin
					if (fifo_in_ready) begin
						idx_r <= 2'(idx_r + 2'h1);
						if (idx_r == 2'(NCH - 1)) begin
							st_r <= LCW_IDLE;
						end
					end
				end
				default: begin
					st_r <= LCW_IDLE;
				end
			endcase
		end
	end

	lcw_fifo #(
		.W(19),
		.DEPTH(DEPTH)
	) u_fifo (
		.clk(CLK),
		.rstn(RSTN),
		.in_valid(st_r == LCW_PUSH),
		.in_ready(fifo_in_ready),
		.in_data({snap_i[idx_r], idx_r, snap_w[idx_r]}),
		.out_valid(OUT_VALID),
		.out_ready(OUT_READY),
		.out_data(fifo_out)
	);

	assign OUT_INVALID = fifo_out[18];
	assign OUT_CH = fifo_out[17:16];
	assign OUT_WORD = fifo_out[15:0];

	// ****************************************************************
	// Checks.
	// ****************************************************************
	live_zero_a: assert property (@(posedge CLK) disable iff (!RSTN)
		ADC_DONE && ADC_CH == 2'h0 |=> lz_r[0] == ($past(ADC_UA) <= `LCW_LZ_UA)) else $error("Live zero flag wrong.");
	line_fault_a: assert property (@(posedge CLK) disable iff (!RSTN)
		ADC_DONE && ADC_CH == 2'h0 && LF_EN[0] && ADC_UA < BRK_UA[0] |=> lf_r[0]) else $error("Lead break not flagged.");
	empty_bits_a: assert property (@(posedge CLK) disable iff (!RSTN)
		status_ok |-> word_w[0][3:2] == 2'b00 && word_w[0][1] == lf_r[0]) else $error("Status bits wrong.");
	subst_invalid_a: assert property (@(posedge CLK) disable iff (!RSTN)
		!SIM_MODE[0] && lf_r[0] && ERR_MODE[0] == LCW_SUBST |-> inv_w[0]) else $error("Substitute not invalid.");
	sim_status_a: assert property (@(posedge CLK) disable iff (!RSTN)
		SIM_MODE[0] |-> inv_w[0] == SIM_INV[0]) else $error("Simulation status wrong.");
	sim_clamp_a: assert property (@(posedge CLK) disable iff (!RSTN)
		SIM_MODE[0] |-> sel_pct[0] >= `LCW_PCT_MIN && sel_pct[0] <= `LCW_PCT_MAX) else $error("Simulation out of range.");
	hart_third_a: assert property (@(posedge CLK) disable iff (!RSTN)
		go && HART_ACTIVE |-> cyc3_r == 2'h0 ##1 hart_wait_r == 21'(HART_CYC - 1)) else $error("HART update spacing wrong.");
	xfer_tick_a: assert property (@(posedge CLK) disable iff (!RSTN)
		go && !HART_ACTIVE |=> st_r == LCW_PUSH && snap_w[0] == $past(word_w[0])) else $error("Transfer not started.");
endmodule // lcw_packer
`default_nettype wire

/* tb/lcw_backplane_model.sv */
// Backplane poller model that takes channel words from the packer.
`timescale 1ns/1ps
`default_nettype none
module lcw_backplane_model (
	// Clock and reset.
	input wire logic clk,
	input wire logic rstn,
	// Test control.
	input wire logic stall,
	input wire logic slow,
	// Word stream from the module.
	input wire logic out_valid,
	output logic out_ready,
	input wire logic [15:0] out_word,
	input wire logic [1:0] out_ch,
	input wire logic out_invalid,
	// Words taken, reported one cycle after the handshake.
	output logic taken,
	output logic [15:0] got_word,
	output logic [1:0] got_ch,
	output logic got_inv
);
	logic [7:0] lfsr_r;
	// The poller only reads; no word ever travels back to the module.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lfsr_r <= 8'h5a;
			out_ready <= 1'b0;
			taken <= 1'b0;
		end else begin
			lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
			out_ready <= !stall && (!slow || lfsr_r[0]);
			taken <= out_valid && out_ready;
		end
	end
	always_ff @(posedge clk) begin
		got_word <= out_word;
		got_ch <= out_ch;
		got_inv <= out_invalid;
	end
endmodule // lcw_backplane_model
`default_nettype wire

/* tb/lcw_packer_test.sv */
// Self-checking bench for the loop current word packer.
`timescale 1ns/1ps
`default_nettype none
module lcw_packer_test;
	import lcw_pkg::*;
	typedef struct {int pts; bit st; logic [3:0] lo; logic inv;} lcw_note_t;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic adc_done = 1'b0;
	logic [1:0] adc_ch = 2'h0;
	logic [15:0] adc_ua = 16'h0000;
	logic [15:0] start_pts = 16'h2710;
	logic [15:0] end_pts = 16'hc350;
	logic hart_active = 1'b0;
	logic scan_en = 1'b1;
	logic stall = 1'b0;
	logic slow = 1'b0;
	logic sim_mode [4], sim_inv [4], lf_en [4], hart_on [4];
	lcw_pct_t sim_pct [4], sub_pct [4];
	lcw_strat_t err_mode [4];
	logic [15:0] brk_ua [4], sc_ua [4];
	logic [7:0] rate [4];
	int ua [4] = '{12000, 3000, 500, 22000};
	int last_pct [4] = '{0, 0, 0, 0};
	logic conv_req, hart_scan_req, out_valid, out_ready, out_invalid, taken, got_inv;
	logic [1:0] conv_ch, scan_ch, out_ch, got_ch;
	logic [15:0] out_word, got_word;
	int errors = 0;
	int tests_run = 0;
	int cyc = 0;
	int scans = 0;
	int prev_ch = -1;
	bit [31:0] seed = 32'h000155a0;
	lcw_note_t q [$];

	always #20 clk = ~clk;

	lcw_packer #(.XFER_CYC(50), .HART_CYC(120), .CONV_CYC(20)) DUT (
		.CLK(clk), .RSTN(rstn), .CONV_REQ(conv_req), .CONV_CH(conv_ch), .ADC_DONE(adc_done),
		.ADC_CH(adc_ch), .ADC_UA(adc_ua), .START_PTS(start_pts), .END_PTS(end_pts),
		.HART_ACTIVE(hart_active), .SCAN_EN(scan_en), .SIM_MODE(sim_mode), .SIM_PCT(sim_pct),
		.SIM_INV(sim_inv), .ERR_MODE(err_mode), .SUB_PCT(sub_pct), .LF_EN(lf_en), .BRK_UA(brk_ua),
		.SC_UA(sc_ua), .RATE(rate), .HART_ON(hart_on), .HART_SCAN_REQ(hart_scan_req),
		.HART_SCAN_CH(scan_ch), .OUT_VALID(out_valid), .OUT_READY(out_ready), .OUT_WORD(out_word),
		.OUT_CH(out_ch), .OUT_INVALID(out_invalid));

	lcw_backplane_model backplane (
		.clk(clk), .rstn(rstn), .stall(stall), .slow(slow), .out_valid(out_valid),
		.out_ready(out_ready), .out_word(out_word), .out_ch(out_ch), .out_invalid(out_invalid),
		.taken(taken), .got_word(got_word), .got_ch(got_ch), .got_inv(got_inv));

	// The converter answers one cycle after each request; between answers the
	// data lines toggle so a stale result can never look valid.
	always @(posedge clk) begin
		adc_done <= conv_req;
		adc_ch <= conv_ch;
		adc_ua <= conv_req ? 16'(ua[conv_ch]) : ~adc_ua;
		cyc <= cyc + 1;
		if (hart_scan_req === 1'b1) begin
			scans <= scans + 1;
			check_num("scan channel", 0, scan_ch);
		end
	end

	// ****************************************************************
	// Expectations and comparisons.
	// ****************************************************************
	function automatic int clampi(int v, int lo, int hi);
		return v < lo ? lo : (v > hi ? hi : v);
	endfunction

	function automatic bit [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic lcw_note_t note(int c);
		lcw_note_t n;
		int pct;
		int s;
		int e;
		bit flt;
		s = start_pts;
		e = end_pts;
		flt = lf_en[c] && (ua[c] < brk_ua[c] || ua[c] > sc_ua[c]);
		pct = clampi(((ua[c] - 4000) * 5) >>> 3, -2500, 12500);
		n.inv = 1'b0;
		if (sim_mode[c]) begin
			pct = clampi(sim_pct[c], -2500, 12500);
			n.inv = sim_inv[c];
		end else if (flt && err_mode[c] == LCW_SUBST) begin
			pct = clampi(sub_pct[c], -2500, 12500);
			n.inv = 1'b1;
		end else if (flt && err_mode[c] == LCW_LAST)
			pct = last_pct[c];
		n.pts = clampi(s + pct * (e - s) / 10000, 0, 65535);
		n.st = s >= 10000 && e <= 50000;
		n.lo = {2'b00, flt, ua[c] <= 3600};
		return n;
	endfunction

	// The scaling multiply is exact for these products, yet a value one point low is also accepted.
	task automatic check_word(lcw_note_t n, logic [15:0] w, logic inv);
		logic [15:0] p;
		logic [15:0] m;
		bit ok;
		p = 16'(n.pts);
		m = n.pts > 0 ? 16'(n.pts - 1) : p;
		ok = n.st ? (w[3:0] === n.lo && (w[15:4] === p[15:4] || w[15:4] === m[15:4])) : (w === p || w === m);
		tests_run++;
		if (!ok || inv !== n.inv) begin
			errors++;
			$display("unexpected word: expected %h low %b inv %b, seen %h inv %b", p, n.lo, n.inv, w, inv);
		end
	endtask

	task automatic check_num(string name, logic [31:0] e, logic [31:0] g);
		tests_run++;
		if (e !== g) begin
			errors++;
			$display("unexpected %s: expected %0d, seen %0d", name, e, g);
		end
	endtask

	always @(posedge clk) begin
		if (taken === 1'b1) begin
			if (prev_ch >= 0)
				check_num("channel order", (prev_ch + 1) % 4, got_ch);
			prev_ch = got_ch;
			if (q.size() > 0)
				check_word(q.pop_front(), got_word, got_inv);
		end
	end

	task automatic settle();
		repeat (260) @(posedge clk);
	endtask

	// Notes are queued between groups so that the next whole group is judged.
	task automatic group();
		@(posedge clk iff (taken === 1'b1 && got_ch === 2'h3));
		@(negedge clk);
		for (int c = 0; c < 4; c++)
			q.push_back(note(c));
		while (q.size() > 0)
			@(posedge clk);
	endtask

	task automatic gap(output int g);
		int t;
		@(posedge clk iff (taken === 1'b1 && got_ch === 2'h0));
		t = cyc;
		@(posedge clk iff (taken === 1'b1 && got_ch === 2'h0));
		g = cyc - t;
	endtask

	task automatic close_out();
		$display("comparisons %0d, mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		$display("unexpected run length: expected finish, seen timeout");
		close_out();
	end

	// ****************************************************************
	// Scenarios.
	// ****************************************************************
	initial begin
		int g;
		int s0;
		int p0;
		int dir;
		int mv;
		for (int c = 0; c < 4; c++) begin
			sim_mode[c] = 1'b0;
			sim_inv[c] = 1'b0;
			lf_en[c] = 1'b1;
			hart_on[c] = 1'b0;
			sim_pct[c] = 16'sh0000;
			sub_pct[c] = 16'sh0000;
			err_mode[c] = LCW_LIVE;
			brk_ua[c] = 16'h03e8;
			sc_ua[c] = 16'h5208;
			rate[c] = 8'h00;
		end
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		// Status layout: random healthy current, live zero, break and short.
		repeat (3) begin
			ua[0] <= 4000 + rnd() % 16001;
			settle();
			group();
		end
		// Scaling out of the status span: full words, simulation, substitution.
		start_pts <= 16'h0000;
		end_pts <= 16'hea60;
		sim_mode[0] <= 1'b1;
		sim_pct[0] <= 16'sh3a98;
		sim_mode[1] <= 1'b1;
		sim_pct[1] <= lcw_pct_t'(rnd() % 12000);
		sim_inv[1] <= 1'b1;
		err_mode[2] <= LCW_SUBST;
		sub_pct[2] <= 16'shf448;
		err_mode[3] <= LCW_SUBST;
		sub_pct[3] <= 16'sh1388;
		settle();
		group();
		// A fault freezes the last valid value.
		sim_mode[0] <= 1'b0;
		sim_mode[1] <= 1'b0;
		ua[2] <= 12000;
		err_mode[2] <= LCW_LAST;
		settle();
		ua[2] <= 500;
		last_pct[2] <= 5000;
		settle();
		group();
		gap(g);
		check_num("transfer gap", 50, g);
		hart_active <= 1'b1;
		hart_on[0] <= 1'b1;
		gap(g);
		gap(g);
		check_num("hart gap", 150, g);
		s0 = scans;
		repeat (160) @(posedge clk);
		check_num("scan count", 2, scans - s0);
		scan_en <= 1'b0;
		s0 = scans;
		repeat (160) @(posedge clk);
		check_num("scan count off", 0, scans - s0);
		// A rate of 1 %/s moves channel 0 by 0.08 % (48 points) per round toward a distant target.
		hart_active <= 1'b0;
		p0 = ((ua[0] - 4000) * 5) >>> 3;
		dir = p0 < 5000 ? 1 : -1;
		rate[0] <= 8'h01;
		ua[0] <= p0 < 5000 ? 20000 : 4000;
		settle();
		@(posedge clk iff (taken === 1'b1 && got_ch === 2'h0));
		mv = (int'(got_word) - 6 * p0) * dir;
		check_num("damped move in steps", 1, mv % 48 == 0 && mv >= 48 && mv <= 240);
		rate[0] <= 8'h00;
		// The poller stalls until the buffer refuses, then drains slowly.
		stall <= 1'b1;
		repeat (600) @(posedge clk);
		check_num("valid while stalled", 1, out_valid);
		stall <= 1'b0;
		slow <= 1'b1;
		repeat (800) @(posedge clk);
		slow <= 1'b0;
		repeat (200) @(posedge clk);
		group();
		close_out();
	end
endmodule // lcw_packer_test
`default_nettype wire
